// >>> src/fsowd_defs.vh
/*
 Constants for the fail-safe output watchdog: register offsets, field
 positions, reset values and timing figures. Assumes 32-bit AXI4-Lite.
*/
`ifndef FSOWD_DEFS_VH
`define FSOWD_DEFS_VH

// Byte offsets of the register words
`define FSOWD_OFF_DIN      8'h00
`define FSOWD_OFF_DOUT     8'h04
`define FSOWD_OFF_FSEDIT   8'h08
`define FSOWD_OFF_FSACT    8'h0c
`define FSOWD_OFF_CTRL     8'h10
`define FSOWD_OFF_HOSTIDLE 8'h14
`define FSOWD_OFF_PEERIDLE 8'h18
`define FSOWD_OFF_STATUS   8'h1c
`define FSOWD_OFF_COILS    8'h20

// Bit location numbering of the single-bit protocol space
`define FSOWD_LOC_DIN_FIRST  16'd1
`define FSOWD_LOC_DIN_LAST   16'd12
`define FSOWD_LOC_DOUT_FIRST 16'd17
`define FSOWD_LOC_DOUT_LAST  16'd22

// Control fields
`define FSOWD_CTRL_HOSTEN  0
`define FSOWD_CTRL_PEEREN  1
`define FSOWD_CTRL_APPLY   2
`define FSOWD_CTRL_CLRTO   3

// Status fields
`define FSOWD_STAT_HOSTTO  0
`define FSOWD_STAT_PEERTO  1
`define FSOWD_STAT_PENDING 2

// Reset values
`define FSOWD_RST_DOUT     6'h00
`define FSOWD_RST_FS       6'h00
`define FSOWD_RST_CTRL     2'h0

// Idle time unit in microseconds and cycles per unit at 50 MHz
`define FSOWD_CLK_HZ       50000000
`define FSOWD_TICK_US      1000
`define FSOWD_TICK_CYC     ((`FSOWD_CLK_HZ / 1000000) * `FSOWD_TICK_US)
`define FSOWD_RST_IDLE     16'd1000

`endif

// >>> src/fsowd_idle_timer.v
/*
 Idle timer: counts ticks since the last qualifying packet and raises a
 one-cycle timeout pulse once per idle period. Assumes a shared tick pulse.
*/
`timescale 1ns/1ns
module fsowd_idle_timer #(
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          enable,
  input  wire          tick,
  input  wire          packetSeen,
  input  wire [CW-1:0] idleLimit,
  output reg           timeoutPulse,
  output reg           expired
);
  reg [CW-1:0] count_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q      <= {CW{1'b0}};
      expired      <= 1'b0;
      timeoutPulse <= 1'b0;
    end else begin
      timeoutPulse <= 1'b0;
      if (!enable || packetSeen) begin
        count_q <= {CW{1'b0}};
        expired <= 1'b0;
      end else if (tick && !expired) begin
        if (count_q >= idleLimit) begin
          expired      <= 1'b1;
          timeoutPulse <= 1'b1;
        end else begin
          count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // fsowd_idle_timer

// >>> src/fsowd_top.v
/*
 Fail-safe output watchdog with AXI4-Lite registers. Twelve inputs and six
 outputs, host-traffic and peer-link watchdogs. Assumes packet-arrival
 strobes come from the network stack, synchronous to clk.
*/
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
// Summary of operation
// - Timeout drives enabled fail-safe channels high
// - Timeout drives disabled fail-safe channels low
// - Host idle beyond limit forces fail-safe outputs
// - Peer idle timeout reports fail-safe values
// - Inputs readable as locations 00001 to 00012
// - Outputs readable and writable at 00017 to 00022
`timescale 1ns/1ns
`include "fsowd_defs.vh"
module fsowd_top #(
  parameter NIN  = 12,
  parameter NOUT = 6,
  parameter TICK = `FSOWD_TICK_CYC
) (
  input  wire            clk,
  input  wire            rst_n,
  input  wire [7:0]      s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [7:0]      s_axi_araddr,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  input  wire [NIN-1:0]  digitalInputBit,
  input  wire            hostPacket,
  input  wire            peerPacket,
  output reg  [NOUT-1:0] digitalOutput,
  output reg             failsafeReport,
  output reg  [NOUT-1:0] failsafeReportValue
);
  reg  [NOUT-1:0] doutReg_q;
  reg  [NOUT-1:0] fsEdit_q;
  reg  [NOUT-1:0] fsActive_q;
  reg  [1:0]      ctrl_q;
  reg  [15:0]     hostIdle_q;
  reg  [15:0]     peerIdle_q;
  reg  [15:0]     tickCnt_q;
  reg             tick_q;
  reg             awHeld_q;
  reg  [7:0]      awAddr_q;
  reg             wHeld_q;
  reg  [31:0]     wData_q;
  reg  [3:0]      wStrb_q;
  reg             hostStick_q;
  reg             peerStick_q;
  wire            hostPulse;
  wire            hostExpired;
  wire            peerPulse;
  wire            peerExpired;
  wire            doWrite;
  wire [31:0]     wMasked;
  wire [15:0]     coilAddr;
  wire [2:0]      coilIdx;
  wire            coilHit;
  wire            clearSticky;
  wire            tickWrap;
  wire            awTake;
  wire            wTake;
  wire            arTake;
  wire [NOUT-1:0] failLevel;
  reg  [NOUT-1:0] outNext_d;
  reg  [31:0]     rdWord_d;

  // Bus response codes
  localparam RESP_OKAY   = 2'b00;
  localparam RESP_SLVERR = 2'b10;

  // Mapped-offset check shared by both channels
  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `FSOWD_OFF_COILS);
    end
  endfunction

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wMasked       = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}}
                         & wData_q;
  assign coilAddr      = wData_q[31:16];
  // Derived write-side decodes and the tick-counter wrap
  assign coilIdx       = coilAddr[2:0] - 3'h1;
  assign coilHit       = (coilAddr >= `FSOWD_LOC_DOUT_FIRST)
                         && (coilAddr <= `FSOWD_LOC_DOUT_LAST);
  assign clearSticky   = doWrite && (awAddr_q == `FSOWD_OFF_CTRL) && wStrb_q[0]
                         && wData_q[`FSOWD_CTRL_CLRTO];
  assign tickWrap      = (tickCnt_q == TICK[15:0] - 16'h0001);
  // Bus handshakes
  assign awTake        = s_axi_awvalid && s_axi_awready;
  assign wTake         = s_axi_wvalid && s_axi_wready;
  assign arTake        = s_axi_arvalid && s_axi_arready;

  // Idle-time unit tick
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 16'h0000;
      tick_q    <= 1'b0;
    end else if (tickWrap) begin
      tickCnt_q <= 16'h0000;
      tick_q    <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 16'h0001;
      tick_q    <= 1'b0;
    end
  end

  fsowd_idle_timer #(.CW(16)) hostTimer (
    .clk          (clk),
    .rst_n        (rst_n),
    .enable       (ctrl_q[`FSOWD_CTRL_HOSTEN]),
    .tick         (tick_q),
    .packetSeen   (hostPacket),
    .idleLimit    (hostIdle_q),
    .timeoutPulse (hostPulse),
    .expired      (hostExpired)
  );

  fsowd_idle_timer #(.CW(16)) peerTimer (
    .clk          (clk),
    .rst_n        (rst_n),
    .enable       (ctrl_q[`FSOWD_CTRL_PEEREN]),
    .tick         (tick_q),
    .packetSeen   (peerPacket),
    .idleLimit    (peerIdle_q),
    .timeoutPulse (peerPulse),
    .expired      (peerExpired)
  );

  // Level each channel takes on timeout
  genvar ch;
  generate
    for (ch = 0; ch < NOUT; ch = ch + 1) begin : gFailLevel
      assign failLevel[ch] = fsActive_q[ch] ? 1'b1
                                            : 1'b0;
    end
  endgenerate

  // Output drive: fail-safe pattern while host timed out
  always @* begin
    if (hostExpired) begin
      outNext_d = failLevel;
    end else begin
      outNext_d = doutReg_q;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digitalOutput <= `FSOWD_RST_DOUT;
    end else begin
      digitalOutput <= outNext_d;
    end
  end

  // Peer-link report toward the host
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      failsafeReport      <= 1'b0;
      failsafeReportValue <= `FSOWD_RST_FS;
    end else begin
      failsafeReport <= peerPulse;
      if (peerPulse) begin
        failsafeReportValue <= fsActive_q;
      end
    end
  end

  // Write channel and register updates
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q     <= 1'b0;
      awAddr_q     <= 8'h00;
      wHeld_q      <= 1'b0;
      wData_q      <= 32'h00000000;
      wStrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      doutReg_q    <= `FSOWD_RST_DOUT;
      fsEdit_q     <= `FSOWD_RST_FS;
      fsActive_q   <= `FSOWD_RST_FS;
      ctrl_q       <= `FSOWD_RST_CTRL;
      hostIdle_q   <= `FSOWD_RST_IDLE;
      peerIdle_q   <= `FSOWD_RST_IDLE;
      hostStick_q  <= 1'b0;
      peerStick_q  <= 1'b0;
    end else begin
      if (awTake) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
        case (awAddr_q)
          `FSOWD_OFF_DOUT: begin
            if (wStrb_q[0]) begin
              doutReg_q <= wData_q[NOUT-1:0];
            end
          end
          `FSOWD_OFF_FSEDIT: begin
            if (wStrb_q[0]) begin
              fsEdit_q <= wData_q[NOUT-1:0];
            end
          end
          `FSOWD_OFF_CTRL: begin
            if (wStrb_q[0]) begin
              ctrl_q <= wData_q[1:0];
              if (wData_q[`FSOWD_CTRL_APPLY]) begin
                fsActive_q <= fsEdit_q;
              end
            end
          end
          `FSOWD_OFF_HOSTIDLE: hostIdle_q <= wMasked[15:0];
          `FSOWD_OFF_PEERIDLE: peerIdle_q <= wMasked[15:0];
          `FSOWD_OFF_COILS: begin
            // Single-bit write: location in [31:16], value in bit 0
            if (coilHit) begin
              doutReg_q[coilIdx] <= wData_q[0];
            end
          end
          default: ;
        endcase
      end
      // Sticky timeout flags: event wins over clear
      if (clearSticky) begin
        hostStick_q <= hostPulse;
        peerStick_q <= peerPulse;
      end else begin
        if (hostPulse) begin
          hostStick_q <= 1'b1;
        end
        if (peerPulse) begin
          peerStick_q <= 1'b1;
        end
      end
    end
  end

  // Read word for the offered address; unmapped words read as zero
  always @* begin
    case (s_axi_araddr)
      `FSOWD_OFF_DIN:      rdWord_d = {{(32-NIN){1'b0}}, digitalInputBit};
      `FSOWD_OFF_DOUT:     rdWord_d = {{(32-NOUT){1'b0}}, digitalOutput};
      `FSOWD_OFF_FSEDIT:   rdWord_d = {{(32-NOUT){1'b0}}, fsEdit_q};
      `FSOWD_OFF_FSACT:    rdWord_d = {{(32-NOUT){1'b0}}, fsActive_q};
      `FSOWD_OFF_CTRL:     rdWord_d = {30'h00000000, ctrl_q};
      `FSOWD_OFF_HOSTIDLE: rdWord_d = {16'h0000, hostIdle_q};
      `FSOWD_OFF_PEERIDLE: rdWord_d = {16'h0000, peerIdle_q};
      `FSOWD_OFF_STATUS:   rdWord_d = {29'h00000000, (fsEdit_q != fsActive_q),
                                       peerStick_q | peerExpired,
                                       hostStick_q | hostExpired};
      // Bit image: inputs at bits 0..11 = locations 1..12, outputs at 16..21 = 17..22
      `FSOWD_OFF_COILS:    rdWord_d = {10'h000, digitalOutput, 4'h0,
                                       digitalInputBit};
      default:             rdWord_d = 32'h00000000;
    endcase
  end

  // Read channel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata  <= rdWord_d;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // fsowd_top

// >>> verification/fsowd_client.sv
/* Network client model: one packet strobe every gap+1 cycles.
   Assumes the bench sets enable and gap. */
`timescale 1ns/1ns
module fsowd_client (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       enable,
  input  wire [7:0] gap,
  output reg        packet
);
  reg [7:0] cnt_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 8'h00;
      packet <= 1'b0;
    end else begin
      packet <= enable && cnt_q == gap;
      cnt_q  <= (cnt_q == gap) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule // fsowd_client

// >>> verification/fsowd_sva.sv
/* Port checker for the fail-safe output watchdog.
   Assumes it is bound onto fsowd_top. */
`timescale 1ns/1ns
module fsowd_sva #(
  parameter NOUT = 6
) (
  input wire            clk,
  input wire            rst_n,
  input wire            s_axi_awvalid,
  input wire            s_axi_awready,
  input wire            s_axi_wvalid,
  input wire            s_axi_wready,
  input wire            s_axi_bvalid,
  input wire            s_axi_bready,
  input wire            s_axi_arvalid,
  input wire            s_axi_arready,
  input wire            s_axi_rvalid,
  input wire            s_axi_rready,
  input wire            failsafeReport,
  input wire [NOUT-1:0] failsafeReportValue
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence arTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wrTake |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  rd_answer_a: assert property (arTake |=> s_axi_rvalid)
    else $error("read answer late");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not cleared");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not cleared");
  report_once_a: assert property (failsafeReport |=> !failsafeReport [*3])
    else $error("report repeated within one period");
  report_value_a: assert property ($changed(failsafeReportValue) |-> failsafeReport)
    else $error("report value moved without report");
endmodule // fsowd_sva

bind fsowd_top fsowd_sva #(.NOUT(NOUT)) u_sva (.*);

// >>> verification/tb.sv
/* Self-checking bench for fsowd_top.
   Assumes TICK shortened to 4 cycles. */
`timescale 1ns/1ns
`include "fsowd_defs.vh"
module tb;
  logic        clk = 0, rst_n = 0, hostEn = 0, peerEn = 0;
  logic [7:0]  awA = 8'h00, arA = 8'h00;
  logic [31:0] wD = 32'h0, rD, r, seed = 32'h9;
  logic        awV = 0, wV = 0, bR = 0, arV = 0, rR = 0;
  logic        awR, wR, bV, arR, rV, hostPk, peerPk, rep;
  logic [1:0]  bRs, rRs, resp;
  logic [11:0] din = 12'h000;
  logic [3:0]  wS = 4'hf;
  logic [5:0]  dout, repVal, expOut, fs;
  int          n_fail = 0, checks = 0, k, n;
  fsowd_top #(.TICK(4)) DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awA),
    .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(wS),
    .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRs), .s_axi_bvalid(bV),
    .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR),
    .s_axi_rdata(rD), .s_axi_rresp(rRs), .s_axi_rvalid(rV), .s_axi_rready(rR),
    .digitalInputBit(din), .hostPacket(hostPk), .peerPacket(peerPk),
    .digitalOutput(dout), .failsafeReport(rep), .failsafeReportValue(repVal));
  fsowd_client hostCl (.clk(clk), .rst_n(rst_n), .enable(hostEn), .gap(8'd3), .packet(hostPk));
  fsowd_client peerCl (.clk(clk), .rst_n(rst_n), .enable(peerEn), .gap(8'd3), .packet(peerPk));
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] coils(input logic [11:0] i, input logic [5:0] o);
    return {10'h0, o, 4'h0, i};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awA <= a;
    wD <= d;
    awV <= 1;
    wV <= 1;
    bR <= 1;
    k = 0;
    do begin
      @(posedge clk);
      if (awR) awV <= 0;
      if (wR) wV <= 0;
      k++;
    end while (bV !== 1'b1 && k < 99);
    if (bV !== 1'b1) n_fail++;
    resp = bRs;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    arA <= a;
    arV <= 1;
    rR <= 1;
    k = 0;
    do begin
      @(posedge clk);
      if (arR) arV <= 0;
      k++;
    end while (rV !== 1'b1 && k < 99);
    if (rV !== 1'b1) n_fail++;
    resp = rRs;
    chk(nm, rD, e);
  endtask
  task end_of_test;
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (int i = 1; i < 8; i++) rc("reset", 8'(i * 4), (i == 5 || i == 6) ? 1000 : 0);
    rc("unmapped", 8'h24, 0);
    chk("rresp", resp, 2'b10);
    wr(8'h24, 32'h1);
    chk("bresp", resp, 2'b10);
    din <= 12'(rnd());
    wr(`FSOWD_OFF_DOUT, rnd());
    expOut = wD[5:0];
    rc("din", `FSOWD_OFF_DIN, din);
    for (int l = 16; l < 24; l++) begin
      r = rnd();
      wr(`FSOWD_OFF_COILS, {l[15:0], 15'h0, r[0]});
      if (l > 16 && l < 23) expOut[l - 17] = r[0];
    end
    chk("out", dout, expOut);
    rc("coils", `FSOWD_OFF_COILS, coils(din, expOut));
    wS <= 4'he;
    wr(`FSOWD_OFF_DOUT, {26'h0000000, ~expOut});
    wS <= 4'hf;
    chk("bresp ok", resp, 2'b00);
    rc("strobe", `FSOWD_OFF_DOUT, expOut);
    fs = ~expOut;
    wr(`FSOWD_OFF_FSEDIT, fs);
    rc("fsidle", `FSOWD_OFF_FSACT, 0);
    rc("pend", `FSOWD_OFF_STATUS, (fs != 6'h00) ? 32'h4 : 32'h0);
    wr(`FSOWD_OFF_HOSTIDLE, 3);
    wr(`FSOWD_OFF_PEERIDLE, 3);
    hostEn <= 1;
    peerEn <= 1;
    wr(`FSOWD_OFF_CTRL, 7);
    rc("fsact", `FSOWD_OFF_FSACT, fs);
    repeat (100) @(posedge clk);
    chk("busy", dout, expOut);
    hostEn <= 0;
    repeat (8) @(posedge clk);
    chk("early", dout, expOut);
    k = 0;
    while (dout !== fs && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk("fsout", dout, fs);
    rc("sticky", `FSOWD_OFF_STATUS, 1);
    hostEn <= 1;
    repeat (10) @(posedge clk);
    chk("resume", dout, expOut);
    rc("held", `FSOWD_OFF_STATUS, 1);
    wr(`FSOWD_OFF_CTRL, 32'hb);
    rc("clear", `FSOWD_OFF_STATUS, 0);
    peerEn <= 0;
    n = 0;
    repeat (100) begin
      @(posedge clk);
      if (rep === 1'b1) begin
        n++;
        chk("repval", repVal, fs);
      end
    end
    chk("repcnt", n, 1);
    end_of_test;
  end
endmodule // tb
